//--- design/module_enable_pkg.sv
// Constants shared by the logical device configuration and enable logic
package module_enable_pkg;
   // ****************************************
   // Logical devices
   // ****************************************
   localparam int NDEV = 9;
   localparam logic [3:0] LD_FLOPPY = 4'h0;
   localparam logic [3:0] LD_KEYBOARD = 4'h4;
   localparam logic [3:0] LD_WAKEUP = 4'h8;
   localparam logic [8:0] HOST_FD_MASK = 9'h00f;
   localparam logic [8:0] WAKE_FD_MASK = 9'h01f;
   localparam logic [8:0] SER_FD_MASK = 9'h01f;
   localparam logic [8:0] VSB_MASK = 9'h1e0;
   // ****************************************
   // Host configuration space
   // ****************************************
   localparam logic [15:0] CFG_PORT_LOW = 16'h002e;
   localparam logic [15:0] CFG_PORT_HIGH = 16'h004e;
   localparam logic [7:0] IDX_LDN = 8'h07;
   localparam logic [7:0] IDX_PART = 8'h20;
   localparam logic [7:0] IDX_CFG_ONE = 8'h21;
   localparam logic [7:0] IDX_HOST_FD = 8'h26;
   localparam logic [7:0] IDX_REV = 8'h27;
   localparam logic [7:0] IDX_WAKE_FD = 8'h2a;
   localparam logic [7:0] IDX_ACT = 8'h30;
   localparam logic [7:0] IDX_BASE0_HI = 8'h60;
   localparam logic [7:0] IDX_BASE0_LO = 8'h61;
   localparam logic [7:0] IDX_BASE1_HI = 8'h62;
   localparam logic [7:0] IDX_BASE1_LO = 8'h63;
   localparam logic [7:0] IDX_IRQ = 8'h70;
   localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
   localparam logic [7:0] IDX_DMA0 = 8'h74;
   localparam logic [7:0] IDX_DMA1 = 8'h75;
   localparam logic [7:0] IDX_VENDOR = 8'hf0;
   localparam int ACT_BIT = 0;
   localparam int GLOB_EN_BIT = 0;
   localparam int HFD_LOCK_BIT = 7;
   // ****************************************
   // Serial-bus side registers
   // ****************************************
   localparam logic [7:0] EC_ALOCK_ONE = 8'h00;
   localparam logic [7:0] EC_ALOCK_TWO = 8'h01;
   localparam logic [7:0] EC_SER_FD = 8'h02;
   localparam logic [7:0] EC_LOCK_CTRL = 8'h03;
   localparam logic [7:0] EC_STATUS = 8'h04;
   localparam int LRS_BIT = 0;
   localparam int UNLOCK_FD_BIT = 1;
   localparam int VIOL_BIT = 0;
   // ****************************************
   // Reset values and decoding
   // ****************************************
   localparam logic [7:0] DMA_NONE = 8'h04;
   localparam logic GLOB_EN_RST = 1'b1;
   localparam int RT_SPAN_BITS = 3;
endpackage : module_enable_pkg

//--- design/enable_if.sv
// Enable inputs and results passed between the top and the enable calculator
`timescale 1ns/1ps
interface enable_if;
   logic [8:0] act;
   logic [8:0] host_fd;
   logic [8:0] wake_fd;
   logic glob_en;
   logic [8:0] alock;
   logic [8:0] ser_fd;
   logic [8:0] enable;
   modport calc (input act, input host_fd, input wake_fd, input glob_en,
      input alock, input ser_fd, output enable);
   modport top (output act, output host_fd, output wake_fd, output glob_en,
      output alock, output ser_fd, input enable);
endinterface : enable_if

//--- design/enable_calc.sv
// Per-module enable from the host path or the embedded-controller path
`timescale 1ns/1ps
module enable_calc (
   enable_if.calc en
);
   logic [8:0] host_en;
   logic [8:0] ec_en;

   always_comb
   begin
      host_en = en.act & ~(en.host_fd & module_enable_pkg::HOST_FD_MASK)
         & ~(en.wake_fd & module_enable_pkg::WAKE_FD_MASK) & {9{en.glob_en}};
      ec_en = ~(en.ser_fd & module_enable_pkg::SER_FD_MASK);
      en.enable = (en.alock & ec_en) | (~en.alock & host_en);
   end
endmodule : enable_calc

//--- design/runtime_decode.sv
// Matches a host I/O address against each device's runtime windows
`timescale 1ns/1ps
module runtime_decode (
   input wire logic [15:0] addr,
   input wire logic [8:0][15:0] base0,
   input wire logic [8:0][15:0] base1,
   output logic [8:0] match
);
   localparam int HB = module_enable_pkg::RT_SPAN_BITS;

   // A zero base means no window is assigned
   function automatic logic in_window(input logic [15:0] a, input logic [15:0] b);
      return (b != 16'h0000) && (a[15:HB] == b[15:HB]);
   endfunction : in_window

   always_comb
   begin
      for (int i = 0; i < module_enable_pkg::NDEV; i++)
      begin
         match[i] = in_window(addr, base0[i]) | in_window(addr, base1[i]);
      end
   end
endmodule : runtime_decode

//--- design/module_enable_config_control.sv
// Logical device configuration space, reset defaults and module enable control
`timescale 1ns/1ps
module module_enable_config_control #(
   parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
   parameter logic [7:0] REV_ID = 8'h01 // Arbitrary value
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic standby_rst_n,
   input wire logic host_soft_reset,
   input wire logic config_base_strap,
   input wire logic host_io_req,
   input wire logic host_io_write,
   input wire logic [15:0] host_io_addr,
   input wire logic [7:0] host_io_wdata,
   output logic host_io_sync,
   output logic [7:0] host_io_rdata,
   output logic [8:0] runtime_sel,
   input wire logic ec_req,
   input wire logic ec_write,
   input wire logic ec_cfg,
   input wire logic [3:0] ec_ldn,
   input wire logic [7:0] ec_index,
   input wire logic [7:0] ec_wdata,
   output logic ec_ready,
   output logic ec_ack,
   output logic [7:0] ec_rdata,
   output logic [8:0] module_enable,
   output logic [8:0] module_clk_en,
   output logic [8:0][3:0] irq_assign,
   output logic [8:0][2:0] dma_assign,
   output logic expansion_external_irq_en,
   output logic legacy_reset,
   output logic lock_violation_flag
);
   typedef struct packed {
      logic [7:0] index;
      logic [3:0] ldn;
      logic [8:0] act;
      logic [8:0][15:0] base0;
      logic [8:0][15:0] base1;
      logic [8:0][7:0] irq;
      logic [8:0][7:0] irq_type;
      logic [8:0][7:0] dma0;
      logic [8:0][7:0] dma1;
      logic [8:0][7:0] vendor;
      logic glob_en;
      logic [7:0] host_fd;
      logic [7:0] wake_fd;
      logic [15:0] cfg_base;
      logic [8:0] alock;
      logic [7:0] ser_fd;
      logic lrs;
      logic viol;
      logic sync;
      logic [7:0] rdata;
      logic [8:0] rt_sel;
      logic ack;
      logic [7:0] ec_rdata;
      logic legacy_rst;
   } state_s;

   state_s q;
   state_s next_q;
   logic [8:0] match;
   logic [8:0] enable;
   enable_if en ();

   // ****************************************
   // Submodules
   // ****************************************
   assign en.act = q.act;
   assign en.host_fd = {1'b0, q.host_fd};
   assign en.wake_fd = {1'b0, q.wake_fd};
   assign en.glob_en = q.glob_en;
   assign en.alock = q.alock;
   assign en.ser_fd = {1'b0, q.ser_fd};
   assign enable = en.enable;

   enable_calc u_calc (
      .en(en.calc)
   );

   runtime_decode u_decode (
      .addr(host_io_addr),
      .base0(q.base0),
      .base1(q.base1),
      .match(match)
   );

   // ****************************************
   // Configuration space access
   // ****************************************
   function automatic logic [7:0] cfg_read(input state_s s, input logic [3:0] ld,
      input logic [7:0] idx);
      logic [7:0] r;
      r = 8'h00;
      case (idx)
         module_enable_pkg::IDX_LDN: r = {4'h0, ld};
         module_enable_pkg::IDX_PART: r = PART_ID;
         module_enable_pkg::IDX_REV: r = REV_ID;
         module_enable_pkg::IDX_CFG_ONE: r = {7'h00, s.glob_en};
         module_enable_pkg::IDX_HOST_FD: r = s.host_fd;
         module_enable_pkg::IDX_WAKE_FD: r = s.wake_fd;
         module_enable_pkg::IDX_ACT: r = {7'h00, s.act[ld]};
         module_enable_pkg::IDX_BASE0_HI: r = s.base0[ld][15:8];
         module_enable_pkg::IDX_BASE0_LO: r = s.base0[ld][7:0];
         module_enable_pkg::IDX_BASE1_HI: r = s.base1[ld][15:8];
         module_enable_pkg::IDX_BASE1_LO: r = s.base1[ld][7:0];
         module_enable_pkg::IDX_IRQ: r = s.irq[ld];
         module_enable_pkg::IDX_IRQ_TYPE: r = s.irq_type[ld];
         module_enable_pkg::IDX_DMA0: r = s.dma0[ld];
         module_enable_pkg::IDX_DMA1: r = s.dma1[ld];
         module_enable_pkg::IDX_VENDOR: r = s.vendor[ld];
         default: r = 8'h00;
      endcase
      return r;
   endfunction : cfg_read

   // Both buses write through here; reads and writes ignore activation state
   function automatic state_s cfg_write(input state_s s, input logic [3:0] ld,
      input logic [7:0] idx, input logic [7:0] d);
      state_s r;
      r = s;
      case (idx)
         module_enable_pkg::IDX_CFG_ONE: r.glob_en = d[module_enable_pkg::GLOB_EN_BIT];
         module_enable_pkg::IDX_HOST_FD:
         begin
            if (!s.host_fd[module_enable_pkg::HFD_LOCK_BIT])
            begin
               r.host_fd = d;
            end
         end
         module_enable_pkg::IDX_WAKE_FD: r.wake_fd = d;
         module_enable_pkg::IDX_ACT: r.act[ld] = d[module_enable_pkg::ACT_BIT];
         module_enable_pkg::IDX_BASE0_HI: r.base0[ld][15:8] = d;
         module_enable_pkg::IDX_BASE0_LO: r.base0[ld][7:0] = d;
         module_enable_pkg::IDX_BASE1_HI: r.base1[ld][15:8] = d;
         module_enable_pkg::IDX_BASE1_LO: r.base1[ld][7:0] = d;
         module_enable_pkg::IDX_IRQ: r.irq[ld] = d;
         module_enable_pkg::IDX_IRQ_TYPE: r.irq_type[ld] = d;
         module_enable_pkg::IDX_DMA0: r.dma0[ld] = d;
         module_enable_pkg::IDX_DMA1: r.dma1[ld] = d;
         module_enable_pkg::IDX_VENDOR: r.vendor[ld] = d;
         default: r = s;
      endcase
      return r;
   endfunction : cfg_write

   // Standard registers back to defaults, activation cleared
   function automatic state_s soft_defaults(input state_s s);
      state_s r;
      r = s;
      r.act = '0;
      r.base0 = '0;
      r.base1 = '0;
      r.irq = '0;
      r.irq_type = '0;
      r.dma0 = {9{module_enable_pkg::DMA_NONE}};
      r.dma1 = {9{module_enable_pkg::DMA_NONE}};
      r.vendor = '0;
      r.legacy_rst = 1'b1;
      return r;
   endfunction : soft_defaults

   // ****************************************
   // State update
   // ****************************************
   always_comb
   begin
      next_q = q;
      next_q.sync = 1'b0;
      next_q.rt_sel = '0;
      next_q.ack = 1'b0;
      next_q.legacy_rst = 1'b0;
      if (host_io_req)
      begin
         if (host_io_addr == q.cfg_base)
         begin
            next_q.sync = 1'b1;
            next_q.rdata = q.index;
            if (host_io_write)
            begin
               next_q.index = host_io_wdata;
            end
         end
         else if (host_io_addr == q.cfg_base + 16'h0001)
         begin
            next_q.sync = 1'b1;
            next_q.rdata = cfg_read(q, q.ldn, q.index);
            if (host_io_write && q.index == module_enable_pkg::IDX_LDN)
            begin
               next_q.ldn = host_io_wdata[3:0];
            end
            else if (host_io_write
               && !(q.alock[q.ldn] && q.index >= module_enable_pkg::IDX_ACT))
            begin
               next_q = cfg_write(next_q, q.ldn, q.index, host_io_wdata);
            end
         end
         else
         begin
            // Locked modules answer no cycle; disabled ones stay silent too
            next_q.rt_sel = match & enable & ~q.alock;
            if ((match & q.alock) != '0)
            begin
               next_q.viol = 1'b1;
            end
         end
      end
      // Controller side is stalled while the host has any I/O request pending, read or write
      if (ec_req && !host_io_req)
      begin
         next_q.ack = 1'b1;
         next_q.ec_rdata = 8'h00;
         if (ec_cfg)
         begin
            next_q.ec_rdata = cfg_read(q, ec_ldn, ec_index);
            if (ec_write)
            begin
               next_q = cfg_write(next_q, ec_ldn, ec_index, ec_wdata);
            end
         end
         else
         begin
            case (ec_index)
               module_enable_pkg::EC_ALOCK_ONE:
               begin
                  next_q.ec_rdata = q.alock[7:0];
                  if (ec_write)
                  begin
                     next_q.alock[7:0] = ec_wdata;
                  end
               end
               module_enable_pkg::EC_ALOCK_TWO:
               begin
                  next_q.ec_rdata = {7'h00, q.alock[8]};
                  if (ec_write)
                  begin
                     next_q.alock[8] = ec_wdata[0];
                  end
               end
               module_enable_pkg::EC_SER_FD:
               begin
                  next_q.ec_rdata = q.ser_fd;
                  if (ec_write)
                  begin
                     next_q.ser_fd = ec_wdata;
                  end
               end
               module_enable_pkg::EC_LOCK_CTRL:
               begin
                  next_q.ec_rdata = {7'h00, q.lrs};
                  if (ec_write)
                  begin
                     next_q.lrs = ec_wdata[module_enable_pkg::LRS_BIT];
                     if (ec_wdata[module_enable_pkg::UNLOCK_FD_BIT])
                     begin
                        next_q.host_fd[module_enable_pkg::HFD_LOCK_BIT] = 1'b0;
                     end
                  end
               end
               module_enable_pkg::EC_STATUS:
               begin
                  next_q.ec_rdata = {7'h00, q.viol};
                  // A violation in the same cycle keeps the flag set
                  if (ec_write && ec_wdata[module_enable_pkg::VIOL_BIT]
                     && !(next_q.viol && !q.viol))
                  begin
                     next_q.viol = 1'b0;
                  end
               end
               default: next_q.ec_rdata = 8'h00;
            endcase
         end
      end
      if (!rst_n)
      begin
         next_q = soft_defaults(next_q);
         next_q.index = 8'h00;
         next_q.ldn = 4'h0;
         next_q.glob_en = module_enable_pkg::GLOB_EN_RST;
         next_q.wake_fd = 8'h00;
         next_q.sync = 1'b0;
         next_q.rt_sel = '0;
         next_q.rdata = 8'h00;
         next_q.cfg_base = config_base_strap ? module_enable_pkg::CFG_PORT_HIGH
            : module_enable_pkg::CFG_PORT_LOW;
         next_q.host_fd = 8'h00;
         if (q.lrs)
         begin
            // Lock survives a main reset when the standby reset owns it
            next_q.host_fd = q.host_fd & (8'h01 << module_enable_pkg::HFD_LOCK_BIT);
         end
         if (!q.lrs)
         begin
            next_q.host_fd[module_enable_pkg::HFD_LOCK_BIT] = 1'b0;
         end
      end
      else if (host_soft_reset)
      begin
         next_q = soft_defaults(next_q);
      end
      if (!standby_rst_n)
      begin
         next_q.alock = '0;
         next_q.ser_fd = 8'h00;
         next_q.lrs = 1'b0;
         next_q.viol = 1'b0;
         next_q.ack = 1'b0;
         next_q.ec_rdata = 8'h00;
         if (q.lrs)
         begin
            next_q.host_fd[module_enable_pkg::HFD_LOCK_BIT] = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      q <= next_q;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign host_io_sync = q.sync;
   assign host_io_rdata = q.rdata;
   assign runtime_sel = q.rt_sel;
   assign ec_ready = !host_io_req;
   assign ec_ack = q.ack;
   assign ec_rdata = q.ec_rdata;
   assign module_enable = enable;
   assign legacy_reset = q.legacy_rst;
   assign lock_violation_flag = q.viol;
   // Not owned by the expansion-bus device, so never gated
   assign expansion_external_irq_en = 1'b1;

   always_comb
   begin
      module_clk_en = enable | module_enable_pkg::VSB_MASK;
      for (int i = 0; i < module_enable_pkg::NDEV; i++)
      begin
         irq_assign[i] = enable[i] ? q.irq[i][3:0] : 4'h0;
         dma_assign[i] = enable[i] ? q.dma0[i][2:0] : module_enable_pkg::DMA_NONE[2:0];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n || !standby_rst_n);

   a_host_path_en: assert property ((!q.alock[0] && !q.glob_en) |-> !module_enable[0])
      else $error("host path enabled without global enable");
   a_ec_path_en: assert property (q.alock[1] |-> module_enable[1] == !q.ser_fd[1])
      else $error("controller path enable mismatch");
   a_ec_ignores: assert property ((q.alock[2] && !q.act[2] && !q.ser_fd[2])
      |-> module_enable[2])
      else $error("host bits not ignored under controller control");
   a_soft_clears: assert property (host_soft_reset |=> q.act == '0 && q.base0 == '0
      && legacy_reset)
      else $error("software reset did not clear activation");
   a_strap_base: assert property (!$past(rst_n) |-> q.cfg_base ==
      ($past(config_base_strap) ? module_enable_pkg::CFG_PORT_HIGH
      : module_enable_pkg::CFG_PORT_LOW))
      else $error("configuration base not taken from strap");
   a_no_sync_off: assert property ((host_io_req && !enable[0]) |=> !runtime_sel[0])
      else $error("runtime select for disabled module");
   a_viol_set: assert property ((host_io_req && (match & q.alock) != '0
      && host_io_addr != q.cfg_base && host_io_addr != q.cfg_base + 16'h0001)
      |=> lock_violation_flag)
      else $error("lock violation not flagged");
   a_locked_wr: assert property ((host_io_req && host_io_write && q.alock[q.ldn]
      && q.index == module_enable_pkg::IDX_ACT && host_io_addr == q.cfg_base + 16'h0001
      && !ec_req && !host_soft_reset) |=> $stable(q.act))
      else $error("host write to locked module taken");
   a_clk_gate: assert property (!module_enable[module_enable_pkg::LD_FLOPPY]
      |-> !module_clk_en[module_enable_pkg::LD_FLOPPY]
      && module_clk_en[module_enable_pkg::LD_WAKEUP]
      && irq_assign[module_enable_pkg::LD_FLOPPY] == 4'h0)
      else $error("disabled module clock or resources not removed");

   c_host_enable: cover property (module_enable[module_enable_pkg::LD_KEYBOARD]
      && !q.alock[module_enable_pkg::LD_KEYBOARD]);
   c_ec_enable: cover property (module_enable[0] && q.alock[0]);
   c_violation: cover property ($rose(lock_violation_flag));
   c_runtime_hit: cover property (runtime_sel != '0);
endmodule : module_enable_config_control

//--- tb/ec_model.sv
// Embedded controller model driving the serial-side register port
`timescale 1ns/1ps
module ec_model (
   input wire logic core_clk,
   input wire logic ec_ready,
   input wire logic ec_ack,
   input wire logic [7:0] ec_rdata,
   output logic ec_req,
   output logic ec_write,
   output logic ec_cfg,
   output logic [3:0] ec_ldn,
   output logic [7:0] ec_index,
   output logic [7:0] ec_wdata
);
   initial
   begin
      ec_req = 1'b0;
      ec_write = 1'b1;
      ec_cfg = 1'b0;
      ec_ldn = 4'h0;
      ec_index = 8'hff;
      ec_wdata = 8'hff;
   end
   // Reads or writes serial-side registers, or configuration space when c is set
   task automatic xfer(input logic c, input logic w, input logic [3:0] ld,
      input logic [7:0] idx, input logic [7:0] d, output logic ok, output logic [7:0] rdv);
      @(posedge core_clk);
      ec_req <= 1'b1;
      ec_cfg <= c;
      ec_write <= w;
      ec_ldn <= ld;
      ec_index <= idx;
      ec_wdata <= d;
      do
         @(posedge core_clk);
      while (ec_ready !== 1'b1);
      // Released lines show inverted data so a stale value never looks valid
      ec_req <= 1'b0;
      ec_ldn <= ~ld;
      ec_index <= ~idx;
      ec_wdata <= ~d;
      @(posedge core_clk);
      ok = ec_ack;
      rdv = ec_rdata;
   endtask : xfer
endmodule : ec_model

//--- tb/test_module_enable_config_control.sv
// Self-checking bench for the module enable and configuration control block
`timescale 1ns/1ps
module test_module_enable_config_control;
   // ****************************************
   // Signals
   // ****************************************
   localparam logic [7:0] PID = 8'h3c; // Arbitrary value
   localparam logic [7:0] RID = 8'h02; // Arbitrary value
   logic core_clk = 1'b0, rst_n = 1'b0, standby_rst_n = 1'b0, host_soft_reset = 1'b0;
   logic config_base_strap = 1'b0, host_io_req = 1'b0, host_io_write = 1'b0;
   logic [15:0] host_io_addr = 16'h0000, port;
   logic [7:0] host_io_wdata = 8'h00, host_io_rdata, ec_index, ec_wdata, rd;
   logic host_io_sync, ec_req, ec_write, ec_cfg, ec_ready, ec_ack, ok, sy;
   logic expansion_external_irq_en, legacy_reset, lock_violation_flag;
   logic [3:0] ec_ldn;
   logic [7:0] ec_rdata, erd;
   logic [8:0] runtime_sel, module_enable, module_clk_en, rs;
   logic [8:0][3:0] irq_assign;
   logic [8:0][2:0] dma_assign;
   int err_total = 0, cmp_count = 0, lr = 0, n, i;
   logic [7:0] sidx[9] = '{module_enable_pkg::IDX_BASE0_HI, module_enable_pkg::IDX_BASE0_LO,
      module_enable_pkg::IDX_BASE1_HI, module_enable_pkg::IDX_BASE1_LO,
      module_enable_pkg::IDX_IRQ, module_enable_pkg::IDX_IRQ_TYPE,
      module_enable_pkg::IDX_DMA0, module_enable_pkg::IDX_DMA1, module_enable_pkg::IDX_VENDOR};
   logic [7:0] sval[9] = '{8'h03, 8'hf0, 8'h02, 8'hf8, 8'h06, 8'h03, 8'h02, 8'h03, 8'ha5};
   logic [7:0] didx[3] = '{8'h26, 8'h2a, 8'h21};
   logic [7:0] dval[3] = '{8'h01, 8'h01, 8'h00};
   logic [7:0] eval[3] = '{8'h00, 8'h00, 8'h01};

   module_enable_config_control #(.PART_ID(PID), .REV_ID(RID)) dut (.core_clk, .rst_n,
      .standby_rst_n, .host_soft_reset, .config_base_strap, .host_io_req, .host_io_write,
      .host_io_addr, .host_io_wdata, .host_io_sync, .host_io_rdata, .runtime_sel, .ec_req,
      .ec_write, .ec_cfg, .ec_ldn, .ec_index, .ec_wdata, .ec_ready, .ec_ack, .ec_rdata,
      .module_enable, .module_clk_en, .irq_assign, .dma_assign, .expansion_external_irq_en,
      .legacy_reset, .lock_violation_flag);
   ec_model ec (.core_clk, .ec_ready, .ec_ack, .ec_req, .ec_write, .ec_cfg, .ec_ldn,
      .ec_index, .ec_wdata, .ec_rdata);

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
      if (legacy_reset === 1'b1)
         lr++;

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic hio(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      host_io_req <= 1'b1;
      host_io_write <= w;
      host_io_addr <= a;
      host_io_wdata <= d;
      @(posedge core_clk);
      host_io_req <= 1'b0;
      host_io_addr <= ~a;
      host_io_wdata <= ~d;
      @(posedge core_clk);
      sy = host_io_sync;
      rd = host_io_rdata;
      rs = runtime_sel;
   endtask : hio
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      hio(1'b1, port, idx);
      hio(1'b1, port + 16'h0001, d);
   endtask : wr
   task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      hio(1'b1, port, idx);
      hio(1'b0, port + 16'h0001, 8'h00);
      chk("sync", 16'(sy), 16'h0001);
      chk(nm, 16'(rd), 16'(exp));
   endtask : rdc
   task automatic ecw(input logic [7:0] idx, input logic [7:0] d);
      ec.xfer(1'b0, 1'b1, 4'h0, idx, d, ok, erd);
      chk("ec_ack", 16'(ok), 16'h0001);
   endtask : ecw
   task automatic ecr(input string nm, input logic c, input logic [7:0] idx,
      input logic [7:0] exp);
      ec.xfer(c, 1'b0, 4'h0, idx, 8'h00, ok, erd);
      chk("ec_ack", 16'(ok), 16'h0001);
      chk(nm, 16'(erd), 16'(exp));
   endtask : ecr
   task automatic do_reset(input logic s);
      @(posedge core_clk);
      rst_n <= 1'b0;
      config_base_strap <= s;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      standby_rst_n <= 1'b1;
      port = s ? module_enable_pkg::CFG_PORT_HIGH : module_enable_pkg::CFG_PORT_LOW;
   endtask : do_reset
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      do_reset(1'b0);
      rdc("part", module_enable_pkg::IDX_PART, PID);
      rdc("rev", module_enable_pkg::IDX_REV, RID);
      wr(module_enable_pkg::IDX_LDN, 8'h00);
      wr(module_enable_pkg::IDX_ACT, 8'hff);
      rdc("act", module_enable_pkg::IDX_ACT, 8'h01);
      for (i = 0; i < 9; i++)
      begin
         wr(sidx[i], sval[i]);
         rdc("std", sidx[i], sval[i]);
      end
      chk("en", 16'(module_enable[0]), 16'h0001);
      chk("irq", 16'(irq_assign[0]), 16'h0006);
      chk("dma", 16'(dma_assign[0]), 16'h0002);
      hio(1'b0, 16'h03f1, 8'h00);
      chk("rt", 16'(rs), 16'h0001);
      // Each host-side disable source alone must turn the floppy module off
      for (i = 0; i < 3; i++)
      begin
         wr(didx[i], dval[i]);
         chk("dis en", 16'(module_enable[0]), 16'h0000);
         chk("dis irq", 16'(irq_assign[0]), 16'h0000);
         chk("dis dma", 16'(dma_assign[0]), 16'h0004);
         chk("dis clk", 16'(module_clk_en[0]), 16'h0000);
         hio(1'b0, 16'h03f1, 8'h00);
         chk("dis rt", 16'(rs), 16'h0000);
         rdc("dis cfg", module_enable_pkg::IDX_IRQ, 8'h06);
         wr(didx[i], eval[i]);
      end
      wr(module_enable_pkg::IDX_CFG_ONE, 8'h00);
      ecw(module_enable_pkg::EC_ALOCK_ONE, 8'h01);
      chk("ec en", 16'(module_enable[0]), 16'h0001);
      wr(module_enable_pkg::IDX_ACT, 8'h00);
      rdc("lock act", module_enable_pkg::IDX_ACT, 8'h01);
      hio(1'b0, 16'h03f1, 8'h00);
      chk("lock rt", 16'(rs), 16'h0000);
      chk("viol", 16'(lock_violation_flag), 16'h0001);
      ecr("ec viol", 1'b0, module_enable_pkg::EC_STATUS, 8'h01);
      ecw(module_enable_pkg::EC_SER_FD, 8'h01);
      chk("ec dis", 16'(module_enable[0]), 16'h0000);
      ecr("ec cfg", 1'b1, module_enable_pkg::IDX_IRQ, 8'h06);
      ecw(module_enable_pkg::EC_STATUS, 8'h01);
      chk("viol clr", 16'(lock_violation_flag), 16'h0000);
      ecw(module_enable_pkg::EC_SER_FD, 8'h00);
      ecw(module_enable_pkg::EC_ALOCK_ONE, 8'h00);
      chk("host back", 16'(module_enable[0]), 16'h0000);
      wr(module_enable_pkg::IDX_HOST_FD, 8'h80);
      wr(module_enable_pkg::IDX_HOST_FD, 8'h81);
      rdc("fd lock", module_enable_pkg::IDX_HOST_FD, 8'h80);
      do_reset(1'b1);
      rdc("fd clr", module_enable_pkg::IDX_HOST_FD, 8'h00);
      rdc("hw act", module_enable_pkg::IDX_ACT, 8'h00);
      chk("vsb clk", 16'(module_clk_en[8:5]), 16'h000f);
      chk("expansion_external_irq", 16'(expansion_external_irq_en), 16'h0001);
      wr(module_enable_pkg::IDX_ACT, 8'h01);
      wr(module_enable_pkg::IDX_BASE0_HI, 8'h03);
      n = lr;
      @(posedge core_clk);
      host_soft_reset <= 1'b1;
      @(posedge core_clk);
      host_soft_reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("legacy", 16'(lr - n), 16'h0001);
      rdc("sr act", module_enable_pkg::IDX_ACT, 8'h00);
      rdc("sr base", module_enable_pkg::IDX_BASE0_HI, 8'h00);
      rdc("sr dma", module_enable_pkg::IDX_DMA0, 8'h04);
      conclude();
   end
   // Whole sequence needs well under 2000 cycles
   initial
   begin
      #100us;
      err_total++;
      conclude();
   end
endmodule : test_module_enable_config_control
